/* File: hdl/uart_pkg.sv */
// uart_pkg: register map, field positions, reset values and framing codes
// for the uart status/control block.
// assumes: a 32-bit classic wishbone slave at byte addresses, 40 MHz clock.
package uart_pkg;

	// buffer depth of both the transmit and the receive queue
	localparam int DEPTH = 4;

	// byte offsets of the registers
	localparam logic [7:0] ADR_STA  = 8'h00; // status and control
	localparam logic [7:0] ADR_TXD  = 8'h04; // transmit character
	localparam logic [7:0] ADR_RXD  = 8'h08; // receive character, pops
	localparam logic [7:0] ADR_IST  = 8'h0C; // sticky event status
	localparam logic [7:0] ADR_IMSK = 8'h10; // event mask
	localparam logic [7:0] ADR_CFG  = 8'h14; // baud divisor and framing

	// status and control field positions
	localparam int TXEN     = 10;
	localparam int TXBF     = 9;
	localparam int TX_EMPTY = 8;
	localparam int RXIS_H   = 7;
	localparam int RXIS_L   = 6;
	localparam int ADR_DET  = 5;
	localparam int RX_QUIET = 4;
	localparam int PAR_BAD  = 3;
	localparam int FRM_BAD  = 2;
	localparam int OVR      = 1;
	localparam int RXDA     = 0;

	// receive character word: data in 8:0, then error bits
	localparam int RXD_PAR_BAD = 9;
	localparam int RXD_FRM_BAD = 10;

	// configuration field positions
	localparam int CFG_NINE = 16;
	localparam int CFG_PAR  = 17;
	localparam int CFG_ODD  = 18;

	// event bits of the sticky status and mask registers
	localparam int IRQ_W   = 3;
	localparam int IRQ_RX  = 0;
	localparam int IRQ_TX  = 1;
	localparam int IRQ_OVR = 2;

	// receive interrupt select codes
	localparam logic [1:0] RXIS_FULL  = 2'h3;
	localparam logic [1:0] RXIS_THREE = 2'h2;

	// reset baud: clock cycles per bit, derived from the rates
	localparam int CLK_HZ  = 40_000_000;
	localparam int BAUD_HZ = 115_200;
	localparam logic [15:0] DIV_RST = 16'(CLK_HZ / BAUD_HZ);

	// receive shifter states
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b000,
		RX_START = 3'b001,
		RX_DATA  = 3'b010,
		RX_PAR   = 3'b011,
		RX_STOP  = 3'b100
	} rx_state_t;

endpackage : uart_pkg

/* File: hdl/uart_rx_shift.sv */
// uart_rx_shift: receive shift register, samples the line mid-bit.
// assumes: rxd_i already synchronous to clk_i; div_i >= 2.
`timescale 1ns/10ps
module uart_rx_shift (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	// line and framing setup
	input  wire logic        rxd_i,
	input  wire logic [15:0] div_i,
	input  wire logic        nine_i,
	input  wire logic        par_en_i,
	input  wire logic        par_odd_i,
	input  wire logic        flush_i,
	// received character
	output logic             done_o,
	output logic [8:0]       data_o,
	output logic             par_bad_o,
	output logic             frm_bad_o,
	output logic             idle_o
);

	// whole state of the shifter
	typedef struct packed {
		uart_pkg::rx_state_t st;   // frame position
		logic [15:0]         tick; // cycles to next sample
		logic [3:0]          idx;  // data bit index
		logic [8:0]          sh;   // assembled character
		logic                done; // one-cycle character strobe
		logic                par_bad; // parity mismatch
		logic                frm_bad; // stop bit low
	} rx_reg_t;

	rx_reg_t q;
	rx_reg_t n;

	// next state of the frame walk
	always_comb begin
		n = q;
		n.done = 1'b0;
		case (q.st)
			uart_pkg::RX_IDLE: begin
				// half a bit first so later samples land mid-bit
				if (!rxd_i) begin
					n.st   = uart_pkg::RX_START;
					n.tick = {1'b0, div_i[15:1]};
					n.sh   = 9'h000;
					n.par_bad = 1'b0;
					n.frm_bad = 1'b0;
				end
			end
			uart_pkg::RX_START: begin
				if (q.tick == 16'h0000) begin
					// a glitch shorter than half a bit is dropped
					if (rxd_i) begin
						n.st = uart_pkg::RX_IDLE;
					end else begin
						n.st   = uart_pkg::RX_DATA;
						n.tick = div_i - 16'h0001;
						n.idx  = 4'h0;
					end
				end else begin
					n.tick = q.tick - 16'h0001;
				end
			end
			uart_pkg::RX_DATA: begin
				if (q.tick == 16'h0000) begin
					n.sh[q.idx] = rxd_i;
					n.tick      = div_i - 16'h0001;
					if (q.idx == (nine_i ? 4'h8 : 4'h7)) begin
						n.st = par_en_i ? uart_pkg::RX_PAR : uart_pkg::RX_STOP;
					end else begin
						n.idx = q.idx + 4'h1;
					end
				end else begin
					n.tick = q.tick - 16'h0001;
				end
			end
			uart_pkg::RX_PAR: begin
				if (q.tick == 16'h0000) begin
					n.par_bad = (^q.sh) ^ rxd_i ^ par_odd_i;
					n.tick = div_i - 16'h0001;
					n.st   = uart_pkg::RX_STOP;
				end else begin
					n.tick = q.tick - 16'h0001;
				end
			end
			uart_pkg::RX_STOP: begin
				if (q.tick == 16'h0000) begin
					n.done = 1'b1;
					n.frm_bad = !rxd_i;
					n.st   = uart_pkg::RX_IDLE;
				end else begin
					n.tick = q.tick - 16'h0001;
				end
			end
			default: begin
				n.st = uart_pkg::RX_IDLE;
			end
		endcase
		// overrun clear empties the shifter too
		if (flush_i) begin
			n.st   = uart_pkg::RX_IDLE;
			n.done = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign done_o = q.done;
	assign data_o = q.sh;
	assign par_bad_o = q.par_bad;
	assign frm_bad_o = q.frm_bad;
	assign idle_o = (q.st == uart_pkg::RX_IDLE);

	property p_done_idle;
		@(posedge clk_i) disable iff (!rst_n_i)
		q.done |-> idle_o;
	endproperty
	a_done_idle: assert property (p_done_idle)
		else $error("receiver not idle after character");

	property p_flush_idle;
		@(posedge clk_i) disable iff (!rst_n_i)
		flush_i |=> (idle_o && !q.done);
	endproperty
	a_flush_idle: assert property (p_flush_idle)
		else $error("receive shifter not emptied by flush");

endmodule : uart_rx_shift

/* File: hdl/uart_sta_lower.sv */
// uart_sta_lower: uart with status/control register, 4-deep queues,
// wishbone register access and a single level interrupt.
// assumes: classic wishbone master, RXD_I synchronous to CLK_I.
//
// Decided for this implementation: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
module uart_sta_lower #(
	parameter int DEPTH = uart_pkg::DEPTH // queue depth, both ways
) (
	// clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_N_I,
	// wishbone slave
	input  wire logic        CYC_I,
	input  wire logic        STB_I,
	input  wire logic        WE_I,
	input  wire logic [7:0]  ADR_I,
	input  wire logic [3:0]  SEL_I,
	input  wire logic [31:0] DAT_I,
	output logic      [31:0] DAT_O,
	output logic             ACK_O,
	// serial line
	input  wire logic        RXD_I,
	output logic             TXD_O,
	output logic             TX_OE_O,
	// interrupt
	output logic             IRQ_O
);

	localparam int PW = $clog2(DEPTH);     // pointer width
	localparam int CW = $clog2(DEPTH + 1); // count width
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [CW-1:0] ONE  = CW'(1);

	// whole block state
	typedef struct packed {
		logic                        ack;     // bus answer
		logic [31:0]                 dat;     // bus read data
		logic                        tx_en;   // transmit enable
		logic [1:0]                  rx_isel; // receive irq select
		logic                        adr_det; // address detect
		logic                        ovr;     // overrun
		logic [15:0]                 div;     // cycles per bit
		logic                        nine;    // nine data bits
		logic                        par_en;  // parity bit present
		logic                        par_odd; // odd parity
		logic [DEPTH-1:0][8:0]       tx_mem;  // transmit queue
		logic [PW-1:0]               tx_rp;
		logic [PW-1:0]               tx_wp;
		logic [CW-1:0]               tx_cnt;
		logic                        tx_busy; // shifter loaded
		logic [11:0]                 tx_fr;   // frame, lsb on line
		logic [3:0]                  tx_left; // bits left before stop
		logic [15:0]                 tx_tick; // cycles left in bit
		logic [DEPTH-1:0][10:0]      rx_mem;  // framing_error_flag, parity_error_flag, data
		logic [PW-1:0]               rx_rp;
		logic [PW-1:0]               rx_wp;
		logic [CW-1:0]               rx_cnt;
		logic                        rx_flush; // empties shifter
		logic                        txd;      // line level
		logic                        tx_oe;    // pin owned by uart
		logic [uart_pkg::IRQ_W-1:0]  ist;      // sticky events
		logic [uart_pkg::IRQ_W-1:0]  imsk;     // event mask
		logic                        irq;
	} state_t;

	state_t q;
	state_t n;

	// receive shifter outputs
	logic       rx_done;
	logic [8:0] rx_data;
	logic       rx_par_bad;
	logic       rx_frm_bad;
	logic       rx_idle;
	// decoded events of this cycle
	logic       bus_go;   // new request seen
	logic       clr_ovr;  // overrun one to zero by software
	logic       rx_take;  // character eligible for the buffer
	logic [15:0] sta;     // status/control read view

	// build the line frame: start, data, optional parity, stop ones
	function automatic logic [11:0] frame_f(input logic [8:0] d,
		input logic nine, input logic pen, input logic odd);
		logic [11:0] f;
		f    = 12'hFFF;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < 8 || nine) begin
				f[i+1] = d[i];
			end
		end
		if (pen) begin
			f[nine ? 10 : 9] = (^(nine ? d : {1'b0, d[7:0]})) ^ odd;
		end
		return f;
	endfunction : frame_f

	uart_rx_shift u_rx (
		.clk_i     (CLK_I),
		.rst_n_i   (RST_N_I),
		.rxd_i     (RXD_I),
		.div_i     (q.div),
		.nine_i    (q.nine),
		.par_en_i  (q.par_en),
		.par_odd_i (q.par_odd),
		.flush_i   (q.rx_flush),
		.done_o    (rx_done),
		.data_o    (rx_data),
		.par_bad_o (rx_par_bad),
		.frm_bad_o (rx_frm_bad),
		.idle_o    (rx_idle)
	);

	// status view; error flags belong to the oldest buffered character
	always_comb begin
		sta = 16'h0000;
		sta[uart_pkg::TXEN] = q.tx_en;
		sta[uart_pkg::TXBF] = (q.tx_cnt == FULL);
		sta[uart_pkg::TX_EMPTY] = !q.tx_busy && (q.tx_cnt == '0);
		sta[uart_pkg::RXIS_H:uart_pkg::RXIS_L] = q.rx_isel;
		sta[uart_pkg::ADR_DET] = q.adr_det;
		sta[uart_pkg::RX_QUIET] = rx_idle;
		sta[uart_pkg::PAR_BAD] = (q.rx_cnt != '0) &&
			q.rx_mem[q.rx_rp][uart_pkg::RXD_PAR_BAD];
		sta[uart_pkg::FRM_BAD] = (q.rx_cnt != '0) &&
			q.rx_mem[q.rx_rp][uart_pkg::RXD_FRM_BAD];
		sta[uart_pkg::OVR] = q.ovr;
		sta[uart_pkg::RXDA] = (q.rx_cnt != '0);
	end

	assign bus_go  = CYC_I && STB_I && !q.ack;
	// in address detect mode with nine data bits only characters with bit 8 set count
	assign rx_take = rx_done && !q.rx_flush &&
		!(q.adr_det && q.nine && !rx_data[8]);

	// next state: bus access, transmit, receive, events
	always_comb begin
		n          = q;
		n.ack      = 1'b0;
		n.rx_flush = 1'b0;
		clr_ovr    = 1'b0;

		// transmit shifter walks the loaded frame
		if (q.tx_busy) begin
			if (q.tx_tick == 16'h0000) begin
				if (q.tx_left == 4'h1) begin
					n.tx_busy = 1'b0;
					n.txd     = 1'b1;
				end else begin
					n.tx_fr   = {1'b1, q.tx_fr[11:1]};
					n.txd     = q.tx_fr[1];
					n.tx_left = q.tx_left - 4'h1;
					n.tx_tick = q.div - 16'h0001;
				end
			end else begin
				n.tx_tick = q.tx_tick - 16'h0001;
			end
		end else if (q.tx_en && q.tx_cnt != '0) begin
			// next queued character moves into the shifter
			n.tx_fr   = frame_f(q.tx_mem[q.tx_rp], q.nine, q.par_en,
				q.par_odd);
			n.txd     = n.tx_fr[0];
			n.tx_left = 4'(q.nine ? 11 : 10) - {3'h0, !q.par_en};
			n.tx_tick = q.div - 16'h0001;
			n.tx_busy = 1'b1;
			n.tx_rp   = q.tx_rp + PW'(1);
			n.tx_cnt  = q.tx_cnt - ONE;
		end

		// register access, one answer per request
		if (bus_go) begin
			n.ack = 1'b1;
			n.dat = 32'h0000_0000;
			if (ADR_I == uart_pkg::ADR_STA) begin
				n.dat = {16'h0000, sta};
				if (WE_I && SEL_I[1]) begin
					n.tx_en = DAT_I[uart_pkg::TXEN];
				end
				if (WE_I && SEL_I[0]) begin
					n.rx_isel = DAT_I[uart_pkg::RXIS_H:uart_pkg::RXIS_L];
					n.adr_det = DAT_I[uart_pkg::ADR_DET];
					clr_ovr   = q.ovr && !DAT_I[uart_pkg::OVR];
				end
			end else if (ADR_I == uart_pkg::ADR_TXD) begin
				// a write to a full queue is dropped
				if (WE_I && SEL_I[0] && q.tx_en && n.tx_cnt != FULL) begin
					n.tx_mem[q.tx_wp] = DAT_I[8:0];
					n.tx_wp  = q.tx_wp + PW'(1);
					n.tx_cnt = n.tx_cnt + ONE;
				end
			end else if (ADR_I == uart_pkg::ADR_RXD) begin
				// reading takes the oldest character out
				if (!WE_I && q.rx_cnt != '0) begin
					n.dat    = {21'h00_0000, q.rx_mem[q.rx_rp]};
					n.rx_rp  = q.rx_rp + PW'(1);
					n.rx_cnt = q.rx_cnt - ONE;
				end
			end else if (ADR_I == uart_pkg::ADR_IST) begin
				n.dat = {29'h0000_0000, q.ist};
				if (WE_I && SEL_I[0]) begin
					n.ist = q.ist & ~DAT_I[uart_pkg::IRQ_W-1:0];
				end
			end else if (ADR_I == uart_pkg::ADR_IMSK) begin
				n.dat = {29'h0000_0000, q.imsk};
				if (WE_I && SEL_I[0]) begin
					n.imsk = DAT_I[uart_pkg::IRQ_W-1:0];
				end
			end else if (ADR_I == uart_pkg::ADR_CFG) begin
				n.dat = {13'h0000, q.par_odd, q.par_en, q.nine, q.div};
				if (WE_I && SEL_I[0]) begin
					n.div[7:0] = DAT_I[7:0];
				end
				if (WE_I && SEL_I[1]) begin
					n.div[15:8] = DAT_I[15:8];
				end
				if (WE_I && SEL_I[2]) begin
					n.nine    = DAT_I[uart_pkg::CFG_NINE];
					n.par_en  = DAT_I[uart_pkg::CFG_PAR];
					n.par_odd = DAT_I[uart_pkg::CFG_ODD];
				end
			end
			// unmapped offsets answer zero and ignore writes
		end

		// transmit disabled: abort, empty queue, give pin back
		if (!n.tx_en) begin
			n.tx_busy = 1'b0;
			n.tx_cnt  = '0;
			n.tx_rp   = '0;
			n.tx_wp   = '0;
			n.txd     = 1'b1;
		end
		n.tx_oe = n.tx_en;
		// last frame finished with nothing queued
		if (q.tx_busy && !n.tx_busy && n.tx_cnt == '0 && n.tx_en) begin
			n.ist[uart_pkg::IRQ_TX] = 1'b1;
		end

		// receive side; the clear empties buffer and shifter, so a
		// character of that same cycle is dropped with the shifter
		if (clr_ovr) begin
			n.ovr      = 1'b0;
			n.rx_cnt   = '0;
			n.rx_rp    = '0;
			n.rx_wp    = '0;
			n.rx_flush = 1'b1;
		end else if (rx_take && !q.ovr) begin
			if (n.rx_cnt == FULL) begin
				n.ovr = 1'b1;
				n.ist[uart_pkg::IRQ_OVR] = 1'b1;
			end else begin
				n.rx_mem[q.rx_wp] = {rx_frm_bad, rx_par_bad, rx_data};
				n.rx_wp  = q.rx_wp + PW'(1);
				n.rx_cnt = n.rx_cnt + ONE;
				case (q.rx_isel)
					uart_pkg::RXIS_FULL: begin
						if (n.rx_cnt == FULL) begin
							n.ist[uart_pkg::IRQ_RX] = 1'b1;
						end
					end
					uart_pkg::RXIS_THREE: begin
						if (n.rx_cnt == CW'(3)) begin
							n.ist[uart_pkg::IRQ_RX] = 1'b1;
						end
					end
					default: begin
						n.ist[uart_pkg::IRQ_RX] = 1'b1;
					end
				endcase
			end
		end

		// level interrupt from any unmasked sticky event
		n.irq = |(n.ist & n.imsk);
	end

	// one register for the whole state
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			q      <= '0;
			q.div  <= uart_pkg::DIV_RST;
			q.txd  <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// outputs straight from flip-flops
	assign DAT_O   = q.dat;
	assign ACK_O   = q.ack;
	assign TXD_O   = q.txd;
	assign TX_OE_O = q.tx_oe;
	assign IRQ_O   = q.irq;

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	property p_busy_owns;
		q.tx_busy |-> (q.tx_oe && q.tx_en);
	endproperty
	a_busy_owns: assert property (p_busy_owns)
		else $error("shifter active without pin ownership");

	property p_dis_abort;
		$fell(q.tx_en) |-> (!q.tx_busy && q.tx_cnt == '0 && q.txd
			&& !q.tx_oe);
	endproperty
	a_dis_abort: assert property (p_dis_abort)
		else $error("transmit disable did not abort");

	property p_tx_bound;
		q.tx_cnt <= FULL;
	endproperty
	a_tx_bound: assert property (p_tx_bound)
		else $error("transmit queue count too large");

	property p_tx_done_evt;
		($fell(q.tx_busy) && q.tx_en && q.tx_cnt == '0) |->
			q.ist[uart_pkg::IRQ_TX];
	endproperty
	a_tx_done_evt: assert property (p_tx_done_evt)
		else $error("transmit idle event missing");

	property p_rx_bound;
		q.rx_cnt <= FULL;
	endproperty
	a_rx_bound: assert property (p_rx_bound)
		else $error("receive buffer count too large");

	property p_rx_any;
		(rx_take && !q.ovr && !clr_ovr && q.rx_cnt != FULL
			&& !q.rx_isel[1]) |=> q.ist[uart_pkg::IRQ_RX];
	endproperty
	a_rx_any: assert property (p_rx_any)
		else $error("receive event missing in any-character mode");

	property p_ovr_set;
		// only the first overflowing character raises the event
		(rx_take && !q.ovr && !clr_ovr && q.rx_cnt == FULL && !bus_go)
			|=> (q.ovr && q.ist[uart_pkg::IRQ_OVR]);
	endproperty
	a_ovr_set: assert property (p_ovr_set)
		else $error("overrun not flagged");

	property p_ovr_clear;
		clr_ovr |=> (!q.ovr && q.rx_cnt == '0 && q.rx_flush);
	endproperty
	a_ovr_clear: assert property (p_ovr_clear)
		else $error("overrun clear did not empty receive path");

	property p_ovr_hold;
		(q.ovr && !clr_ovr) |=> (q.rx_cnt <= $past(q.rx_cnt));
	endproperty
	a_ovr_hold: assert property (p_ovr_hold)
		else $error("character stored during overrun");

endmodule : uart_sta_lower

/* File: sim/uart_peer.sv */
// uart_peer: serial peer on the far side of the uart's line pins.
// assumes: one clock shared with the uart; bit time of DIV clock cycles.
`timescale 1ns/10ps
module uart_peer #(
	parameter int DIV = 4 // cycles per bit, must match the divisor
) (
	// clock
	input  wire logic clk_i,
	// uart transmit side, watched
	input  wire logic txd_i,
	input  wire logic oe_i,
	// uart receive side, driven
	output logic      rxd_o
);
	logic [7:0] got; // last character seen on the transmit line

	// the line rests at mark level between frames, like a pulled-up wire
	initial rxd_o = 1'b1;

	// one bit for a whole bit time, changed just after an edge
	task automatic put_bit(input logic b);
		rxd_o <= b;
		repeat (DIV) @(posedge clk_i);
	endtask : put_bit

	// start, data lsb first, optional even parity, stop, one idle bit;
	// par 2 sends the wrong parity, stop 0 sends a broken frame
	task automatic send(input logic [8:0] d, input int nb, input int par,
		input logic stop);
		logic p;
		p = (par == 2);
		@(posedge clk_i);
		put_bit(1'b0);
		for (int i = 0; i < nb; i++) begin
			put_bit(d[i]);
			p = p ^ d[i];
		end
		if (par != 0) begin
			put_bit(p);
		end
		put_bit(stop);
		put_bit(1'b1);
	endtask : send

	// receiver: only frames sent while the uart owns the pin count
	initial begin
		got = 8'h00;
		forever begin
			@(negedge txd_i);
			if (oe_i === 1'b1) begin
				// centre on the start bit, then sample each data bit mid-way
				repeat (DIV / 2) @(posedge clk_i);
				for (int i = 0; i < 8; i++) begin
					repeat (DIV) @(posedge clk_i);
					got[i] = txd_i;
				end
				repeat (DIV) @(posedge clk_i);
			end
		end
	end
endmodule : uart_peer

/* File: sim/tb_uart_sta_lower.sv */
// tb_uart_sta_lower: register-level tests of the uart status block.
// assumes: uart_peer on the line pins, classic wishbone single cycles.
`timescale 1ns/10ps
module tb_uart_sta_lower;
	localparam int DIV = 4; // short bit time keeps the run small

	// clock, reset and bus
	logic        clk   = 1'b0;
	logic        rst_n = 1'b0;
	logic        cyc   = 1'b0;
	logic        stb   = 1'b0;
	logic        we    = 1'b0;
	logic [7:0]  adr   = 8'h00;
	logic [3:0]  sel   = 4'hF;
	logic [31:0] wdat  = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	// line and interrupt
	logic        rxd, txd, tx_oe, irq;
	// bookkeeping
	int          errors   = 0;
	int          n_checks = 0;
	logic [31:0] q;
	int          n;

	always #12.5 clk = ~clk;

	uart_sta_lower #(.DEPTH(uart_pkg::DEPTH)) i_dut (.CLK_I(clk),
		.RST_N_I(rst_n), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
		.SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .RXD_I(rxd),
		.TXD_O(txd), .TX_OE_O(tx_oe), .IRQ_O(irq));

	uart_peer #(.DIV(DIV)) i_peer (.clk_i(clk), .txd_i(txd), .oe_i(tx_oe),
		.rxd_o(rxd));

	// compare and count; unknowns never match
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask : chk

	// one classic cycle: hold everything until ack is sampled high
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 50);
		r = rdat;
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
		if (k >= 50) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
	endtask : bus

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(a, 1'b1, d, r);
	endtask : wr

	// read, keep only the fields of interest, compare
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input string nm);
		logic [31:0] r;
		bus(a, 1'b0, 32'h0000_0000, r);
		chk(nm, e, r & m);
	endtask : rd

	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict

	// watchdog: the whole sequence needs well under 10k cycles
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		print_verdict();
	end

	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(uart_pkg::ADR_STA, 32'hFFFF_FFFF, 32'h0000_0110, "sta rst");
		chk("oe rst", 32'h0000_0000, tx_oe);
		rd(8'h40, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
		wr(uart_pkg::ADR_CFG, 32'h0000_0004);
		// single character out, done event unmasked
		wr(uart_pkg::ADR_IMSK, 32'h0000_0002);
		wr(uart_pkg::ADR_STA, 32'h0000_0400);
		wr(uart_pkg::ADR_TXD, 32'h0000_00A5);
		chk("oe on", 32'h0000_0001, tx_oe);
		rd(uart_pkg::ADR_STA, 32'h0000_0100, 32'h0000_0000, "shift busy");
		n = 0;
		while (irq !== 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		chk("tx irq", 32'h0000_0001, irq);
		chk("tx char", 32'h0000_00A5, i_peer.got);
		rd(uart_pkg::ADR_STA, 32'h0000_0300, 32'h0000_0100, "tx idle");
		wr(uart_pkg::ADR_IST, 32'h0000_0002);
		repeat (2) @(posedge clk);
		chk("irq clr", 32'h0000_0000, irq);
		// fill the queue until its full flag is set, then abort by disabling
		wr(uart_pkg::ADR_IMSK, 32'h0000_0000);
		n = 0;
		q = 32'h0000_0000;
		while (q[9] !== 1'b1 && n < 8) begin
			wr(uart_pkg::ADR_TXD, 32'h0000_0030 + 32'(n));
			bus(uart_pkg::ADR_STA, 1'b0, 32'h0000_0000, q);
			n++;
		end
		chk("tx full", 32'h0000_0001, q[9]);
		chk("tx queued", 32'h0000_0000, q[8]);
		wr(uart_pkg::ADR_STA, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk("oe off", 32'h0000_0000, tx_oe);
		chk("txd off", 32'h0000_0001, txd);
		rd(uart_pkg::ADR_STA, 32'h0000_0300, 32'h0000_0100, "tx reset");
		// one character in, event masked: no interrupt
		wr(uart_pkg::ADR_IST, 32'h0000_0007);
		fork
			i_peer.send(9'h03C, 8, 0, 1'b1);
			begin
				repeat (3 * DIV) @(posedge clk);
				rd(uart_pkg::ADR_STA, 32'h0000_0010, 32'h0000_0000, "rx busy");
			end
		join
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_STA, 32'h0000_001F, 32'h0000_0011, "rx flags");
		rd(uart_pkg::ADR_IST, 32'h0000_0001, 32'h0000_0001, "ist rx");
		chk("irq masked", 32'h0000_0000, irq);
		rd(uart_pkg::ADR_RXD, 32'h0000_07FF, 32'h0000_003C, "rx data");
		rd(uart_pkg::ADR_STA, 32'h0000_0001, 32'h0000_0000, "rx empty");
		// every receive interrupt select code, four characters each
		for (int s = 0; s < 4; s++) begin
			wr(uart_pkg::ADR_STA, 32'(s) << 6);
			wr(uart_pkg::ADR_IMSK, 32'h0000_0001);
			wr(uart_pkg::ADR_IST, 32'h0000_0001);
			for (int c = 1; c <= 4; c++) begin
				i_peer.send(9'(8'h10 + c), 8, 0, 1'b1);
				repeat (4) @(posedge clk);
				rd(uart_pkg::ADR_IST, 32'h0000_0001, 32'((s < 2) || (c == 4) ||
					(s == 2 && c == 3)), "rx event");
				chk("rx irq", 32'((s < 2) || (c == 4) || (s == 2 && c == 3)),
					irq);
			end
			for (int c = 1; c <= 4; c++) begin
				rd(uart_pkg::ADR_RXD, 32'h0000_01FF, 32'(8'h10 + c), "rx order");
			end
		end
		// overrun: six characters into four places
		wr(uart_pkg::ADR_STA, 32'h0000_0000);
		for (int c = 1; c <= 6; c++) i_peer.send(9'(8'h20 + c), 8, 0, 1'b1);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_STA, 32'h0000_0003, 32'h0000_0003, "overrun");
		rd(uart_pkg::ADR_IST, 32'h0000_0004, 32'h0000_0004, "ist ovr");
		rd(uart_pkg::ADR_RXD, 32'h0000_01FF, 32'h0000_0021, "oldest");
		wr(uart_pkg::ADR_STA, 32'h0000_0000);
		rd(uart_pkg::ADR_STA, 32'h0000_0003, 32'h0000_0000, "flushed");
		i_peer.send(9'h030, 8, 0, 1'b1);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_RXD, 32'h0000_01FF, 32'h0000_0030, "after ovr");
		// parity and framing errors of the oldest character
		wr(uart_pkg::ADR_CFG, 32'h0002_0004);
		i_peer.send(9'h055, 8, 2, 1'b1);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_STA, 32'h0000_000C, 32'h0000_0008, "par bad");
		rd(uart_pkg::ADR_RXD, 32'h0000_0600, 32'h0000_0200, "rxd par");
		i_peer.send(9'h055, 8, 1, 1'b0);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_STA, 32'h0000_000C, 32'h0000_0004, "frm bad");
		rd(uart_pkg::ADR_RXD, 32'h0000_0600, 32'h0000_0400, "rxd frm");
		// odd parity: the peer's inverted even parity is now correct
		wr(uart_pkg::ADR_CFG, 32'h0006_0004);
		i_peer.send(9'h055, 8, 2, 1'b1);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_STA, 32'h0000_000C, 32'h0000_0000, "odd par");
		rd(uart_pkg::ADR_RXD, 32'h0000_07FF, 32'h0000_0055, "rxd odd");
		// address detect in nine-bit mode, then ignored in eight-bit mode
		wr(uart_pkg::ADR_CFG, 32'h0001_0004);
		wr(uart_pkg::ADR_STA, 32'h0000_0020);
		rd(uart_pkg::ADR_STA, 32'h0000_04E0, 32'h0000_0020, "ctl rb");
		i_peer.send(9'h055, 9, 0, 1'b1);
		i_peer.send(9'h1AA, 9, 0, 1'b1);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_RXD, 32'h0000_01FF, 32'h0000_01AA, "addr only");
		wr(uart_pkg::ADR_CFG, 32'h0000_0004);
		i_peer.send(9'h077, 8, 0, 1'b1);
		repeat (4) @(posedge clk);
		rd(uart_pkg::ADR_RXD, 32'h0000_01FF, 32'h0000_0077, "eight bit");
		print_verdict();
	end
endmodule : tb_uart_sta_lower
